// [core/burst_sram_byte_write_port.sv]
// Purpose: Write lane masking and two-beat burst sequencing of a burst memory
// Assumes: K is sampled from a pin; its falling level edge stands for the K# rise
// Notes: Writes pass a 32-word buffer before they reach the array
//
// Contract
// R1: Nine-bit organisation stores its lane when the enable is low, else nothing.
// R2: Eighteen-bit organisation: two independent low enables gate bits 0-8 and 9-17.
// R3: Thirty-six-bit organisation: four low enables gate lanes 0-8 to 27-35 in order.
// R4: Enables sampled separately at K rise and K# rise; differing masks honoured.
// R5: Enables act only inside a started write cycle.
// R6: Each address gains one internal low bit selecting the beat.
// R7: Beat order is always base plus 0, then base plus 1.
// R8: Every read or write cycle ends after exactly two beats.
// R9: Read and write machines run independently and may overlap.
// R10: Both machines advance on K, never on output clocks.
// R11: Write starts with write select low at K; words at K then K#.
// R12: Read starts with read select low at K; words at next K# then K. Code delivers them one K period later.
// R13: Both selects high is no operation; read outputs released.
// R14: Control inputs are registered only on the K rise.
`timescale 1ns/1ps
`include "burst_sram_cfg.svh"
// ***************************************
// Write buffer
// ***************************************
module wr_beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = store[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage carries no reset so it can map onto RAM
  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wp_q] <= in_data;
    end
  end
endmodule

// ***************************************
// Burst memory port
// ***************************************
module burst_sram_byte_write_port #(
  parameter int DATA_W = `DATA_W_DEF,
  parameter int ADDR_W = `ADDR_W_DEF
) (
  // System
  input wire logic sys_clk,
  input wire logic resetn,
  // Memory bus pins from the host
  input wire logic k_pin,
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic [ADDR_W-1:0] addr_pin,
  input wire logic [DATA_W-1:0] d_pin,
  input wire logic [DATA_W/`LANE_W-1:0] lane_en_n,
  // Read data pins
  output logic [DATA_W-1:0] q_pin_q,
  output logic q_oe_q,
  output logic q_valid_q,
  // Status
  output logic wbuf_full_q
);
  localparam int LANES = DATA_W / `LANE_W;
  localparam int IN_W = 3 + ADDR_W + DATA_W + LANES;

  // ***************************************
  // Pin synchronisers
  // ***************************************
  logic [IN_W-1:0] pins, s1_q, s2_q;
  logic k_s3_q;
  logic k_s, rsel_n_s, wsel_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] d_s;
  logic [LANES-1:0] en_n_s;
  logic k_rise, kn_rise;

  assign pins = {k_pin, read_sel_n, write_sel_n, addr_pin, d_pin, lane_en_n};
  assign {k_s, rsel_n_s, wsel_n_s, addr_s, d_s, en_n_s} = s2_q;
  assign k_rise = k_s && !k_s3_q;
  // K# is the complement of K, so its rise is the K fall
  assign kn_rise = !k_s && k_s3_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '1;
      s2_q <= '1;
      k_s3_q <= 1'b1;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      k_s3_q <= k_s;
    end
  end

  // ***************************************
  // Write machine
  // ***************************************
  burst_sram_pkg::wr_state_t ws_q, ws_d;
  logic [ADDR_W-1:0] wa_q, wa_d;
  burst_sram_pkg::wr_beat_t beat;
  logic beat_valid, wbuf_ready, wbuf_full_d;

  always_comb begin
    ws_d = ws_q;
    wa_d = wa_q;
    beat_valid = 1'b0;
    beat = '0;
    unique case (ws_q)
      burst_sram_pkg::W_IDLE: begin
        if (k_rise && !wsel_n_s) begin // R11 R14
          ws_d = burst_sram_pkg::W_SECOND;
          wa_d = addr_s;
          beat_valid = 1'b1; // R5
          beat.addr = {addr_s, 1'b0}; // R6 R7
          beat.data = d_s;
          beat.lane_en_n = en_n_s; // R4
        end
      end
      burst_sram_pkg::W_SECOND: begin
        if (kn_rise) begin // R4 R11
          ws_d = burst_sram_pkg::W_IDLE; // R8
          beat_valid = 1'b1;
          beat.addr = {wa_q, 1'b1}; // R7
          beat.data = d_s;
          beat.lane_en_n = en_n_s;
        end
      end
    endcase
    wbuf_full_d = !wbuf_ready;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ws_q <= burst_sram_pkg::W_IDLE;
      wa_q <= '0;
      wbuf_full_q <= 1'b0;
    end else begin
      ws_q <= ws_d;
      wa_q <= wa_d;
      wbuf_full_q <= wbuf_full_d;
    end
  end

  // ***************************************
  // Buffer and array
  // ***************************************
  logic [DATA_W-1:0] mem [2**(ADDR_W+1)];
  burst_sram_pkg::wr_beat_t drain;
  logic drain_valid, drain_ready, rd_fetch;
  logic [ADDR_W:0] rd_addr;
  logic [DATA_W-1:0] old_word, merged;

  // A beat offered while the buffer is full is lost; wbuf_full_q warns the host
  wr_beat_fifo #(.WIDTH($bits(burst_sram_pkg::wr_beat_t)), .DEPTH(`WBUF_DEPTH)) wbuf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(beat_valid),
    .in_ready(wbuf_ready),
    .in_data(beat),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain)
  );

  // Reads own the single array port; the drain waits a cycle
  assign drain_ready = !rd_fetch; // R9
  assign old_word = mem[drain.addr];

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign merged[l*`LANE_W +: `LANE_W] = drain.lane_en_n[l] ? old_word[l*`LANE_W +: `LANE_W]
                                          : drain.data[l*`LANE_W +: `LANE_W]; // R1 R2 R3
  end

  always_ff @(posedge sys_clk) begin
    if (drain_valid && drain_ready) begin
      mem[drain.addr] <= merged;
    end
  end

  // ***************************************
  // Read machine
  // ***************************************
  burst_sram_pkg::rd_state_t rs_q, rs_d;
  logic [ADDR_W-1:0] ra_q, ra_d, pa_q, pa_d;
  logic pend_q, pend_d;
  logic [DATA_W-1:0] q_d;
  logic oe_d, qv_d;

  always_comb begin
    rs_d = rs_q;
    ra_d = ra_q;
    pa_d = pa_q;
    pend_d = pend_q;
    q_d = q_pin_q;
    oe_d = q_oe_q;
    qv_d = 1'b0;
    rd_fetch = 1'b0;
    rd_addr = {ra_q, 1'b0};
    if (k_rise) begin // R10 R14
      pend_d = !rsel_n_s; // R12
      pa_d = addr_s;
    end
    unique case (rs_q)
      burst_sram_pkg::R_IDLE: begin
        if (k_rise) begin
          oe_d = 1'b0; // R13
          if (pend_q) begin
            rs_d = burst_sram_pkg::R_FIRST;
            ra_d = pa_q;
          end
        end
      end
      burst_sram_pkg::R_FIRST: begin
        if (kn_rise) begin
          rd_fetch = 1'b1;
          rd_addr = {ra_q, 1'b0}; // R6 R7
          rs_d = burst_sram_pkg::R_SECOND;
        end
      end
      burst_sram_pkg::R_SECOND: begin
        if (k_rise) begin
          rd_fetch = 1'b1;
          rd_addr = {ra_q, 1'b1}; // R7
          rs_d = pend_q ? burst_sram_pkg::R_FIRST : burst_sram_pkg::R_IDLE; // R8
          ra_d = pa_q;
        end
      end
    endcase
    if (rd_fetch) begin
      q_d = mem[rd_addr];
      oe_d = 1'b1;
      qv_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rs_q <= burst_sram_pkg::R_IDLE;
      ra_q <= '0;
      pa_q <= '0;
      pend_q <= 1'b0;
      q_pin_q <= '0;
      q_oe_q <= 1'b0;
      q_valid_q <= 1'b0;
    end else begin
      rs_q <= rs_d;
      ra_q <= ra_d;
      pa_q <= pa_d;
      pend_q <= pend_d;
      q_pin_q <= q_d;
      q_oe_q <= oe_d;
      q_valid_q <= qv_d;
    end
  end
endmodule

// [core/burst_sram_cfg.svh]
// Purpose: Constants for the two-beat burst memory port
// Assumes: One lane is nine bits wide
// Notes: Included by the package and the design file
`ifndef BURST_SRAM_CFG_SVH
`define BURST_SRAM_CFG_SVH
`define LANE_W 9
`define BURST_LEN 2
`define WBUF_DEPTH 32
`define DATA_W_DEF 36
`define ADDR_W_DEF 19
`define SYNC_RST 3'h0
`define WBUF_CNT_RST 6'h00
`endif

// [core/burst_sram_pkg.sv]
// Purpose: Types shared by the burst memory port
// Assumes: Widths fixed at the default organisation
// Notes: The beat struct travels through the write buffer
`include "burst_sram_cfg.svh"
package burst_sram_pkg;
  typedef struct packed {
    logic [`ADDR_W_DEF:0] addr;
    logic [`DATA_W_DEF-1:0] data;
    logic [`DATA_W_DEF/`LANE_W-1:0] lane_en_n;
  } wr_beat_t;
  typedef enum logic [1:0] {
    W_IDLE = 2'h1,
    W_SECOND = 2'h2
  } wr_state_t;
  typedef enum logic [2:0] {
    R_IDLE = 3'h1,
    R_FIRST = 3'h2,
    R_SECOND = 3'h4
  } rd_state_t;
endpackage

// [testbench/host_bus.sv]
// Purpose: Host controller model driving the memory bus
// Assumes: K high phase of 6 sys_clk cycles, low phase of 13
// Notes: K stands low between frames
`timescale 1ns/1ps
// ****
// Host
// ****
module host_bus (
  // Clock
  input wire logic sys_clk,
  // Bus toward the device
  output logic k_pin,
  output logic read_sel_n,
  output logic write_sel_n,
  output logic [18:0] addr_pin,
  output logic [35:0] d_pin,
  output logic [3:0] lane_en_n
);
  initial begin
    k_pin = 1'b1;
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    addr_pin = 19'h00000;
    d_pin = 36'h0;
    lane_en_n = 4'hf;
  end
  task automatic cycle(input logic rd_n, input logic wr_n, input logic [18:0] a,
    input logic [35:0] d0, input logic [35:0] d1, input logic [3:0] m0, input logic [3:0] m1);
    @(negedge sys_clk);
    k_pin = 1'b0;
    repeat (6) @(negedge sys_clk);
    k_pin = 1'b1;
    read_sel_n = rd_n;
    write_sel_n = wr_n;
    addr_pin = a;
    d_pin = d0;
    lane_en_n = m0;
    repeat (6) @(negedge sys_clk);
    k_pin = 1'b0;
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    addr_pin = ~a;
    d_pin = d1;
    lane_en_n = m1;
    repeat (6) @(negedge sys_clk);
    // Released lines show the inverse so stale values cannot pass
    d_pin = ~d1;
    lane_en_n = ~m1;
  endtask
endmodule

// [testbench/port_checker.sv]
// Purpose: Port checks for the burst memory port
// Assumes: Host K rises every 19 sys_clk cycles and stays high for 6
// Notes: Bound to the port after the module
`timescale 1ns/1ps
// ****
// Checker
// ****
module port_checker #(
  parameter int DATA_W = 36
) (
  // Clock, reset and host pins
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic k_pin,
  input wire logic read_sel_n,
  // Read side and write buffer status
  input wire logic [DATA_W-1:0] q_pin_q,
  input wire logic q_oe_q,
  input wire logic q_valid_q,
  input wire logic wbuf_full_q
);
  // Second word lands 40 cycles after its read start; leave margin for the pair check
  localparam int RD_SPAN = 48;
  logic [6:0] kh_q;
  logic [6:0] kh_d;
  logic [7:0] age_q;
  logic [7:0] age_d;
  logic odd_q;
  logic odd_d;
  // Age since the last read start saturates so it never wraps
  always_comb begin
    kh_d = {kh_q[5:0], k_pin};
    age_d = (age_q == 8'hff) ? age_q : age_q + 8'h01;
    if (k_pin && !kh_q[0] && !read_sel_n) begin
      age_d = 8'h00;
    end
    odd_d = odd_q ^ q_valid_q;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      kh_q <= 7'h7f;
      age_q <= 8'hff;
      odd_q <= 1'b0;
    end else begin
      kh_q <= kh_d;
      age_q <= age_d;
      odd_q <= odd_d;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  reset_quiet_a: assert property ($rose(resetn) |-> !q_oe_q && !q_valid_q && !wbuf_full_q)
    else $error("outputs active after reset");
  strobe_once_a: assert property (q_valid_q |=> !q_valid_q)
    else $error("word strobe too long");
  word_held_a: assert property ($changed(q_pin_q) |-> q_valid_q)
    else $error("read data moved without strobe");
  drive_with_word_a: assert property (q_valid_q |-> q_oe_q)
    else $error("word given while not driving");
  k_timed_a: assert property (q_valid_q |-> |(kh_q[6:2] ^ kh_q[5:1]))
    else $error("word not timed by a K edge");
  read_caused_a: assert property (q_valid_q |-> age_q < RD_SPAN)
    else $error("word without a read start");
  burst_pair_a: assert property (age_q == RD_SPAN |-> !odd_q)
    else $error("odd number of read words");
  release_idle_a: assert property ($fell(q_oe_q) |-> age_q > 8'h1e)
    else $error("output released inside a read");
endmodule
bind burst_sram_byte_write_port port_checker #(.DATA_W(DATA_W)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .k_pin(k_pin), .read_sel_n(read_sel_n), .q_pin_q(q_pin_q), .q_oe_q(q_oe_q), .q_valid_q(q_valid_q),
  .wbuf_full_q(wbuf_full_q));

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the burst memory port
// Assumes: Array contents are undefined until written and survive reset
// Notes: Expected words come from a lane-merge model
`timescale 1ns/1ps
// ****
// Bench
// ****
module tb_top;
  logic sys_clk;
  logic resetn;
  logic k_pin;
  logic read_sel_n;
  logic write_sel_n;
  logic [18:0] addr_pin;
  logic [35:0] d_pin;
  logic [35:0] q_pin_q;
  logic [3:0] lane_en_n;
  logic q_oe_q;
  logic q_valid_q;
  logic wbuf_full_q;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [35:0] mem_m [int];
  logic [35:0] got[$];
  // Rows: beat0 mask, beat1 mask
  logic [7:0] rows [6] = '{8'h00, 8'hed, 8'hb7, 8'hf0, 8'h5a, 8'hff};
  host_bus host (.sys_clk(sys_clk), .k_pin(k_pin), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
    .addr_pin(addr_pin), .d_pin(d_pin), .lane_en_n(lane_en_n));
  burst_sram_byte_write_port dut (.sys_clk(sys_clk), .resetn(resetn), .k_pin(k_pin), .read_sel_n(read_sel_n),
    .write_sel_n(write_sel_n), .addr_pin(addr_pin), .d_pin(d_pin), .lane_en_n(lane_en_n), .q_pin_q(q_pin_q),
    .q_oe_q(q_oe_q), .q_valid_q(q_valid_q), .wbuf_full_q(wbuf_full_q));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Sample away from the edge that launches the read word
  always @(negedge sys_clk) begin
    if (q_valid_q === 1'b1) got.push_back(q_pin_q);
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  function automatic logic [35:0] merge(logic [35:0] old, logic [35:0] nw, logic [3:0] m);
    merge = old;
    for (int l = 0; l < 4; l++) if (!m[l]) merge[9*l +: 9] = nw[9*l +: 9];
  endfunction
  task automatic chk(string name, logic [35:0] exp, logic [35:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", name, exp, seen);
    end
  endtask
  // One bus cycle, then idle frames with lanes enabled but no write
  task automatic op(logic rd_n, logic wr_n, logic [18:0] a, logic [35:0] d0, logic [35:0] d1,
    logic [3:0] m0, logic [3:0] m1);
    logic [35:0] e0;
    logic [35:0] e1;
    // Beats reach the array long before the read fetch, so a read sees a write of its own frame
    if (!wr_n) begin
      mem_m[int'({a, 1'b0})] = merge(mem_m[int'({a, 1'b0})], d0, m0);
      mem_m[int'({a, 1'b1})] = merge(mem_m[int'({a, 1'b1})], d1, m1);
    end
    e0 = mem_m[int'({a, 1'b0})];
    e1 = mem_m[int'({a, 1'b1})];
    got.delete();
    host.cycle(rd_n, wr_n, a, d0, d1, m0, m1);
    repeat (3) host.cycle(1'b1, 1'b1, ~a, ~d1, ~d1, 4'h0, 4'h0);
    chk("oe_idle", 36'h0, {35'h0, q_oe_q});
    chk("full", 36'h0, {35'h0, wbuf_full_q});
    if (!rd_n) begin
      chk("count", 36'h2, 36'(got.size()));
      chk("word0", e0, got.size() > 0 ? got[0] : 'x);
      chk("word1", e1, got.size() > 1 ? got[1] : 'x);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    foreach (rows[i]) begin
      op(1'b1, 1'b0, 19'(i), 36'h0, 36'h0, 4'h0, 4'h0);
      op(1'b1, 1'b0, 19'(i), 36'hf_ffff_ffff, 36'he_eeee_eeee, rows[i][7:4], rows[i][3:0]);
      op(1'b0, 1'b1, 19'(i), 36'h0, 36'h0, 4'hf, 4'hf);
    end
    // Read and write of one address in the same frame: read sees the new data
    op(1'b1, 1'b0, 19'h7ffff, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0);
    op(1'b0, 1'b0, 19'h7ffff, 36'ha_5a5a_5a5a, 36'h5_a5a5_a5a5, 4'h6, 4'h9);
    op(1'b0, 1'b1, 19'h7ffff, 36'h0, 36'h0, 4'hf, 4'hf);
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("oe", 36'h0, {35'h0, q_oe_q});
    // Release with K low: the stale K fall seen after reset must be harmless
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    op(1'b1, 1'b0, 19'h2a5a5, 36'h3_c3c3_c3c3, 36'hc_3c3c_3c3c, 4'h0, 4'h0);
    op(1'b0, 1'b1, 19'h2a5a5, 36'h0, 36'h0, 4'hf, 4'hf);
    report_and_stop();
  end
endmodule
